// ---- rtl/rcos_top.sv ----
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rcos_params.svh"

module rcos_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // clock sources
    input wire logic [16:0] chan_rcv_clk,
    input wire logic ext_clock_in_first,
    input wire logic ext_clock_in_second,
    // reference clock pins
    output logic ref_clock_out_first,
    output logic ref_clock_out_first_oe,
    output logic ref_clock_out_second,
    output logic ref_clock_out_second_oe
);
    import rcos_pkg::*;

    localparam int NSRC = `RCOS_NUM_CHAN + 2;
    localparam logic [7:0] ACT_CYC = 8'(`RCOS_ACT_CYCLES);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_meta_q, rst_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    rcos_bus_req_t req;
    logic [7:0] cfg_first_q, cfg_first_d;
    logic [7:0] div_first_q, div_first_d;
    logic [7:0] cfg_second_q, cfg_second_d;
    logic [7:0] div_second_q, div_second_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] status;
    logic [NSRC-1:0] active_q;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // reserved bit 7 reads zero
    function automatic logic [7:0] cfg_mask(input logic [7:0] v);
        return {1'b0, v[6:0]};
    endfunction

    function automatic logic [7:0] div_mask(input logic [7:0] v);
        return {5'h00, v[`RCOS_DIV_EXP_MSB:0]};
    endfunction

    always_comb begin
        cfg_first_d = cfg_first_q;
        div_first_d = div_first_q;
        cfg_second_d = cfg_second_q;
        div_second_d = div_second_q;
        if (req.wr) begin
            unique case (req.addr)
                `RCOS_OFS_CFG_FIRST: begin
                    cfg_first_d = cfg_mask(req.wdata);
                end
                `RCOS_OFS_DIV_FIRST: begin
                    div_first_d = div_mask(req.wdata);
                end
                `RCOS_OFS_CFG_SECOND: begin
                    cfg_second_d = cfg_mask(req.wdata);
                end
                `RCOS_OFS_DIV_SECOND: begin
                    div_second_d = div_mask(req.wdata);
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `RCOS_OFS_CFG_FIRST: rdata_d = cfg_first_q;
                `RCOS_OFS_DIV_FIRST: rdata_d = div_first_q;
                `RCOS_OFS_CFG_SECOND: rdata_d = cfg_second_q;
                `RCOS_OFS_DIV_SECOND: rdata_d = div_second_q;
                `RCOS_OFS_STATUS: rdata_d = status;
                `RCOS_OFS_CHAN_LO: rdata_d = active_q[7:0];
                `RCOS_OFS_CHAN_MID: rdata_d = active_q[15:8];
                `RCOS_OFS_CHAN_HI: rdata_d = {7'h00, active_q[16]};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_first_q <= `RCOS_CFG_RESET;
            div_first_q <= `RCOS_DIV_RESET;
            cfg_second_q <= `RCOS_CFG_RESET;
            div_second_q <= `RCOS_DIV_RESET;
            rdata_q <= 8'h00;
        end else begin
            cfg_first_q <= cfg_first_d;
            div_first_q <= div_first_d;
            cfg_second_q <= cfg_second_d;
            div_second_q <= div_second_d;
            rdata_q <= rdata_d;
        end
    end

    // read data stands only in the cycle after the strobe
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // free-running clocks, one per line rate

    logic [`RCOS_NCO_W-1:0] nco_t1_q, nco_t1_d;
    logic [`RCOS_NCO_W-1:0] nco_e1_q, nco_e1_d;
    logic free_t1, free_e1;

    // jitter of one 25 ns period is accepted; average rate is exact enough
    always_comb begin
        nco_t1_d = nco_t1_q + `RCOS_NCO_STEP_T1;
        nco_e1_d = nco_e1_q + `RCOS_NCO_STEP_E1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            nco_t1_q <= '0;
            nco_e1_q <= '0;
        end else begin
            nco_t1_q <= nco_t1_d;
            nco_e1_q <= nco_e1_d;
        end
    end

    assign free_t1 = nco_t1_q[`RCOS_NCO_W-1];
    assign free_e1 = nco_e1_q[`RCOS_NCO_W-1];

    ////////////////////////////////////////////////////////////////////////
    // source activity monitor

    logic [NSRC-1:0] src_vec;
    logic [NSRC-1:0] prev_q, prev_d;
    logic [NSRC-1:0] active_d;
    logic [7:0] idle_q [NSRC];
    logic [7:0] idle_d [NSRC];

    assign src_vec = {ext_clock_in_second, ext_clock_in_first, chan_rcv_clk};

    always_comb begin
        prev_d = src_vec;
        for (int i = 0; i < NSRC; i++) begin
            idle_d[i] = idle_q[i];
            active_d[i] = active_q[i];
            if (src_vec[i] && !prev_q[i]) begin
                idle_d[i] = 8'h00;
                active_d[i] = 1'b1;
            end else if (idle_q[i] == ACT_CYC) begin
                active_d[i] = 1'b0;
            end else begin
                idle_d[i] = idle_q[i] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
            active_q <= '0;
            for (int i = 0; i < NSRC; i++) begin
                idle_q[i] <= 8'h00;
            end
        end else begin
            prev_q <= prev_d;
            active_q <= active_d;
            for (int i = 0; i < NSRC; i++) begin
                idle_q[i] <= idle_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stages

    rcos_out_cfg_t out_cfg_first, out_cfg_second;
    rcos_pin_t pin_first, pin_second;
    logic free_first, free_second;

    assign out_cfg_first.enable = cfg_first_q[`RCOS_CFG_EN_BIT];
    assign out_cfg_first.rate_e1 = cfg_first_q[`RCOS_CFG_RATE_BIT];
    assign out_cfg_first.source =
        cfg_first_q[`RCOS_CFG_SRC_MSB:`RCOS_CFG_SRC_LSB];
    assign out_cfg_first.div_exp = div_first_q[2:0];
    assign out_cfg_second.enable = cfg_second_q[`RCOS_CFG_EN_BIT];
    assign out_cfg_second.rate_e1 = cfg_second_q[`RCOS_CFG_RATE_BIT];
    assign out_cfg_second.source =
        cfg_second_q[`RCOS_CFG_SRC_MSB:`RCOS_CFG_SRC_LSB];
    assign out_cfg_second.div_exp = div_second_q[2:0];

    // free-running rate follows the rate bit in each output's own configuration register
    assign free_first = out_cfg_first.rate_e1 ? free_e1 : free_t1;
    assign free_second = out_cfg_second.rate_e1 ? free_e1 : free_t1;

    rcos_ref_out u_out_first (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(out_cfg_first),
        .chan_clk(chan_rcv_clk),
        .ext_clk(ext_clock_in_first),
        .free_clk(free_first),
        .pin(pin_first)
    );

    rcos_ref_out u_out_second (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(out_cfg_second),
        .chan_clk(chan_rcv_clk),
        .ext_clk(ext_clock_in_second),
        .free_clk(free_second),
        .pin(pin_second)
    );

    assign ref_clock_out_first = pin_first.level;
    assign ref_clock_out_first_oe = pin_first.oe;
    assign ref_clock_out_second = pin_second.level;
    assign ref_clock_out_second_oe = pin_second.oe;

    // status: external activity and present pin levels
    assign status = {4'h0, pin_second.level, pin_first.level,
                     active_q[NSRC-1], active_q[NSRC-2]};

endmodule

// ---- rtl/rcos_params.svh ----
`ifndef RCOS_PARAMS_SVH
`define RCOS_PARAMS_SVH

// register indices on the 4-bit register port
`define RCOS_ADDR_W 4
`define RCOS_DATA_W 8
`define RCOS_OFS_CFG_FIRST 4'h0
`define RCOS_OFS_DIV_FIRST 4'h1
`define RCOS_OFS_CFG_SECOND 4'h2
`define RCOS_OFS_DIV_SECOND 4'h3
`define RCOS_OFS_STATUS 4'h4
`define RCOS_OFS_CHAN_LO 4'h5
`define RCOS_OFS_CHAN_MID 4'h6
`define RCOS_OFS_CHAN_HI 4'h7

// configuration register fields
`define RCOS_CFG_SRC_LSB 0
`define RCOS_CFG_SRC_MSB 4
`define RCOS_CFG_RATE_BIT 5
`define RCOS_CFG_EN_BIT 6
`define RCOS_DIV_EXP_MSB 2

// reset values: output disabled, free-running source, T1 rate
`define RCOS_CFG_RESET 8'h12
`define RCOS_DIV_RESET 8'h00

// source codes
`define RCOS_NUM_CHAN 17
`define RCOS_SRC_EXT 5'h11
`define RCOS_SRC_FREE 5'h12

// phase step of a 24-bit accumulator at 40 MHz
`define RCOS_NCO_W 24
`define RCOS_NCO_STEP_T1 24'h09e1b1
`define RCOS_NCO_STEP_E1 24'h0d1b71

// a source with no rising edge in this window is reported dead
`define RCOS_CLK_PERIOD_NS 25
`define RCOS_ACT_WINDOW_NS 2000
`define RCOS_ACT_CYCLES (`RCOS_ACT_WINDOW_NS / `RCOS_CLK_PERIOD_NS)

`endif

// ---- rtl/rcos_pkg.sv ----
package rcos_pkg;

    // per-output settings as seen by the output stage
    typedef struct packed {
        logic enable;
        logic rate_e1;
        logic [4:0] source;
        logic [2:0] div_exp;
    } rcos_out_cfg_t;

    // output pin: level plus drive enable, high-Z resolved outside
    typedef struct packed {
        logic level;
        logic oe;
    } rcos_pin_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rcos_bus_req_t;

    function automatic logic rcos_pick(input logic [4:0] sel,
                                       input logic [16:0] chan,
                                       input logic ext,
                                       input logic free);
        logic r;
        r = free;
        if (sel < 5'd17) begin
            r = chan[sel];
        end else if (sel == 5'h11) begin
            r = ext;
        end
        return r;
    endfunction

endpackage

// ---- rtl/rcos_ref_out.sv ----
`timescale 1ns/1ps
`include "rcos_params.svh"

module rcos_ref_out (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // settings and candidate sources
    input rcos_pkg::rcos_out_cfg_t cfg,
    input wire logic [16:0] chan_clk,
    input wire logic ext_clk,
    input wire logic free_clk,
    // pin
    output rcos_pkg::rcos_pin_t pin
);
    import rcos_pkg::*;

    logic src;
    logic prev_q, prev_d;
    logic [7:0] cnt_q, cnt_d;
    logic lvl_q, lvl_d;
    logic oe_q, oe_d;

    always_comb begin
        src = rcos_pick(cfg.source, chan_clk, ext_clk, free_clk);
        prev_d = src;
        cnt_d = cnt_q;
        if (src && !prev_q) begin
            cnt_d = cnt_q + 8'h01;
        end
        // divide by 2^k: bit k-1 of the edge count
        if (cfg.div_exp == 3'h0) begin
            lvl_d = src;
        end else begin
            lvl_d = cnt_q[cfg.div_exp - 3'h1];
        end
        oe_d = cfg.enable;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
            lvl_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
            oe_q <= oe_d;
        end
    end

    // level held low while disabled so the pad sees no activity
    assign pin.level = lvl_q & oe_q;
    assign pin.oe = oe_q;

endmodule

// ---- sim/rcos_top_props.sv ----
`timescale 1ns/1ps
module rcos_top_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // sources
    input wire logic [16:0] chan_rcv_clk,
    input wire logic ext_clock_in_first,
    input wire logic ext_clock_in_second,
    // pins
    input wire logic ref_clock_out_first,
    input wire logic ref_clock_out_first_oe,
    input wire logic ref_clock_out_second,
    input wire logic ref_clock_out_second_oe
);
    logic [6:0] c1_q, c2_q;
    logic [2:0] d1_q, d2_q, q_q;
    logic s1, s2;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // sources passed in so the assigns follow every channel change
    function automatic logic pk(input logic [4:0] s, input logic e,
                                input logic [16:0] c);
        return (s == 5'h11) ? e : c[s];
    endfunction
    assign s1 = pk(c1_q[4:0], ext_clock_in_first, chan_rcv_clk);
    assign s2 = pk(c2_q[4:0], ext_clock_in_second, chan_rcv_clk);
    // shadow settings; q_q counts quiet cycles so routes have settled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            c1_q <= 7'h12;
            c2_q <= 7'h12;
            d1_q <= 3'h0;
            d2_q <= 3'h0;
            q_q <= 3'h0;
        end else begin
            q_q <= reg_wr ? 3'h0 : q_q + {2'h0, q_q != 3'h7};
            if (reg_wr && reg_addr == 4'h0) c1_q <= reg_wdata[6:0];
            if (reg_wr && reg_addr == 4'h1) d1_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == 4'h2) c2_q <= reg_wdata[6:0];
            if (reg_wr && reg_addr == 4'h3) d2_q <= reg_wdata[2:0];
        end
    end
    sequence s_cfg1;
        reg_wr && reg_addr == 4'h0;
    endsequence
    sequence s_cfg2;
        reg_wr && reg_addr == 4'h2;
    endsequence
    property p_oe_first;
        s_cfg1 |-> ##2 ref_clock_out_first_oe == $past(reg_wdata[6], 2);
    endproperty
    a_oe_first: assert property (p_oe_first) else $error("oe1 bad");
    property p_oe_second;
        s_cfg2 |-> ##2 ref_clock_out_second_oe == $past(reg_wdata[6], 2);
    endproperty
    a_oe_second: assert property (p_oe_second) else $error("oe2 bad");
    property p_off_first;
        q_q == 3'h7 && !c1_q[6] |-> !ref_clock_out_first_oe
            && !ref_clock_out_first;
    endproperty
    a_off_first: assert property (p_off_first) else $error("lvl1 on");
    property p_off_second;
        q_q == 3'h7 && !c2_q[6] |-> !ref_clock_out_second_oe
            && !ref_clock_out_second;
    endproperty
    a_off_second: assert property (p_off_second) else $error("off2");
    property p_src_first;
        (q_q == 3'h7 && d1_q == 3'h0 && c1_q[6] && c1_q[4:0] < 5'h12)
            |-> ref_clock_out_first == $past(s1);
    endproperty
    a_src_first: assert property (p_src_first) else $error("src1 bad");
    property p_src_second;
        (q_q == 3'h7 && d2_q == 3'h0 && c2_q[6] && c2_q[4:0] < 5'h12)
            |-> ref_clock_out_second == $past(s2);
    endproperty
    a_src_second: assert property (p_src_second) else $error("src2 bad");
    property p_rd_div;
        reg_rd && reg_addr == 4'h1 |=> reg_rdata == {5'h00, d1_q};
    endproperty
    a_rd_div: assert property (p_rd_div) else $error("div read bad");
endmodule

// ---- sim/rcos_ref_sink.sv ----
`timescale 1ns/1ps
// board timing input: resolves the pad, counts rising edges
module rcos_ref_sink (
    // clock and control
    input wire logic clk_sys,
    input wire logic clr,
    // pin
    input wire logic level,
    input wire logic oe,
    // observations
    output logic [15:0] edges,
    output logic floating
);
    wire pad;
    logic last_q;
    assign pad = oe ? level : 1'bz;
    assign floating = (pad === 1'bz);
    always @(posedge clk_sys) begin
        last_q <= pad;
        if (clr) edges <= 16'h0000;
        else if (pad === 1'b1 && last_q === 1'b0) edges <= edges + 16'h1;
    end
endmodule

// ---- sim/test_rcos_top.sv ----
`timescale 1ns/1ps
module test_rcos_top;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] v;
        logic oe;
    } rcos_row_t;
    logic clk_sys, arst_n, reg_wr, reg_rd, clr;
    logic ext1 = 1'b0;
    logic ext2 = 1'b0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [16:0] chan_rcv_clk = 17'h00000;
    logic [18:0] s1_q;
    wire [7:0] reg_rdata;
    wire [15:0] n1, n2;
    wire o1, e1, o2, e2, f1, f2;
    int cnt = 0;
    int fails = 0;
    int cmp_count = 0;
    rcos_row_t rows [6] = '{'{4'h0, 8'h51, 1'b1}, '{4'h0, 8'h00, 1'b0},
        '{4'h2, 8'h71, 1'b1}, '{4'h2, 8'h10, 1'b0},
        '{4'h0, 8'h52, 1'b1}, '{4'h2, 8'h11, 1'b0}};
    rcos_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chan_rcv_clk(chan_rcv_clk), .ext_clock_in_first(ext1),
        .ext_clock_in_second(ext2), .ref_clock_out_first(o1),
        .ref_clock_out_first_oe(e1), .ref_clock_out_second(o2),
        .ref_clock_out_second_oe(e2));
    rcos_ref_sink i_sink1 (.clk_sys(clk_sys), .clr(clr), .level(o1),
        .oe(e1), .edges(n1), .floating(f1));
    rcos_ref_sink i_sink2 (.clk_sys(clk_sys), .clr(clr), .level(o2),
        .oe(e2), .edges(n2), .floating(f2));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // sources: external rates roughly T1 and E1 at this clock
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
        for (int i = 0; i < 17; i++)
            chan_rcv_clk[i] <= ((cnt / (i + 2)) % 2) == 1;
        ext1 <= (cnt % 26) < 13;
        ext2 <= (cnt % 20) < 10;
        s1_q <= {ext2, ext1, chan_rcv_clk};
    end
    function automatic logic ex(input logic [4:0] s, input logic e,
                                input logic [16:0] c);
        return (s == 5'h11) ? e : c[s];
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_byte(reg_rdata, exp);
    endtask
    task automatic run(input logic [3:0] a, input logic [7:0] v,
                       input logic oe);
        wr(a, v);
        repeat (4) @(posedge clk_sys);
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            chk_bit(a[1] ? e2 : e1, oe);
            chk_bit(a[1] ? f2 : f1, !oe);
            if (v[4:0] < 5'h12) chk_bit(a[1] ? o2 : o1, oe &
                ex(v[4:0], s1_q[17 + a[1]], s1_q[16:0]));
        end
    endtask
    task automatic meas(input logic [3:0] a, input logic [7:0] v,
                        input int n, input logic [15:0] lo,
                        input logic [15:0] hi);
        logic [15:0] got;
        wr(a, v);
        repeat (4) @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
        got = a[1] ? n2 : n1;
        chk_bit(got >= lo && got <= hi, 1'b1);
    endtask
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        {reg_wr, reg_rd, clr} = 3'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(4'h0, 8'h12);
        rd(4'h2, 8'h12);
        rd(4'h1, 8'h00);
        wr(4'h8, 8'hff);
        rd(4'h8, 8'h00);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h07);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h7f);
        wr(4'h1, 8'h00);
        foreach (rows[r]) run(rows[r].a, rows[r].v, rows[r].oe);
        for (int i = 0; i < 17; i++) begin
            run(4'h0, 8'h40 + i[7:0], 1'b1);
            run(4'h2, 8'h40 + i[7:0], 1'b1);
        end
        for (int k = 0; k < 4; k++) begin
            logic [15:0] nom;
            nom = 16'd40 >> k;
            wr(4'h1, k[7:0]);
            meas(4'h0, 8'h40, 160, nom - 16'd1, nom + 16'd1);
        end
        wr(4'h1, 8'h00);
        meas(4'h0, 8'h52, 4000, 16'd150, 16'd159);
        meas(4'h0, 8'h72, 4000, 16'd200, 16'd209);
        meas(4'h2, 8'h52, 4000, 16'd150, 16'd159);
        meas(4'h2, 8'h72, 4000, 16'd200, 16'd209);
        // both outputs off: status shows live externals, low levels
        wr(4'h0, 8'h12);
        wr(4'h2, 8'h12);
        rd(4'h4, 8'h03);
        rd(4'h5, 8'hff);
        rd(4'h6, 8'hff);
        rd(4'h7, 8'h01);
        wr(4'h0, 8'h45);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk_bit(e1, 1'b0);
        chk_bit(f1, 1'b1);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(4'h0, 8'h12);
        give_verdict;
    end
    // whole run is about 17300 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        give_verdict;
    end
endmodule
bind rcos_top rcos_top_props u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_rcv_clk(chan_rcv_clk),
    .ext_clock_in_first(ext_clock_in_first),
    .ext_clock_in_second(ext_clock_in_second),
    .ref_clock_out_first(ref_clock_out_first),
    .ref_clock_out_first_oe(ref_clock_out_first_oe),
    .ref_clock_out_second(ref_clock_out_second),
    .ref_clock_out_second_oe(ref_clock_out_second_oe));
